// *** design/gpio_ports.sv ***
// Top: analog, clock-pin and small ports plus the direction register bank
//
// Operation
// - Analog port is four bits, latched, per-bit direction from its direction register.
// - Analog-port pin drives only when digital is selected and direction is output.
// - Analog and input: converted only when selected; analog with output prohibited.
// - Reset leaves all four analog-port pins as inputs; analog or digital mode follows analog_pin_config.
// - Clock-pin port is five bits, latched, per-bit direction control.
// - Only clock-pin bit 0 has a pull-up, active only as input.
// - Reset makes every clock-pin port bit an input.
// - Clock-pin bit 0 feeds interrupt and low-voltage inputs; bits 1-4 oscillators.
// - Oscillator selector takes bits 1-4, overriding direction and latch.
// - Small port bit 0 is output-only with no direction control.
// - Small port bits 1 and 2 are bidirectional with pull-ups as inputs.
// - Output-only pin drives low during reset.
// - Direction bits choose input or output; byte and bit writes accepted.
// - Direction registers reset to FFH, small port one to FEH.
// - Direction 0 enables output buffer, 1 disables it.
// - Port read returns pin level for inputs, latch for outputs, 0 for analog-mode and oscillator bits.
// - Output latches reset to 00H.
`timescale 1ns/1ps
module gpio_ports (
  input  wire logic                                  ref_clk,
  input  wire logic                                  nrst,
  input  wire logic [15:0]                           bus_addr,
  input  wire logic [7:0]                            bus_wdata,
  input  wire logic                                  bus_wr,
  input  wire logic                                  bus_bit_wr,
  input  wire logic [2:0]                            bus_bit_sel,
  input  wire logic                                  bus_rd,
  output logic      [7:0]                            bus_rdata_r,
  input  wire logic [gpio_pkg::ANALOG_WIDTH-1:0]     analog_pin_config,
  input  wire logic [3:0]                            converter_channel_select,
  input  wire logic [7:0]                            oscillator_mode_select,
  input  wire logic [gpio_pkg::ANALOG_WIDTH-1:0]     analog_pin_in,
  output logic      [gpio_pkg::ANALOG_WIDTH-1:0]     analog_pin_out_r,
  output logic      [gpio_pkg::ANALOG_WIDTH-1:0]     analog_pin_oe_r,
  output logic      [gpio_pkg::ANALOG_WIDTH-1:0]     analog_convert_r,
  input  wire logic [gpio_pkg::CLOCKPIN_WIDTH-1:0]   clockpin_in,
  output logic      [gpio_pkg::CLOCKPIN_WIDTH-1:0]   clockpin_out_r,
  output logic      [gpio_pkg::CLOCKPIN_WIDTH-1:0]   clockpin_oe_r,
  output logic      [gpio_pkg::CLOCKPIN_WIDTH-1:0]   clockpin_osc_r,
  output logic                                       clockpin_pullup_r,
  output logic                                       external_irq_zero_r,
  output logic                                       ext_low_voltage_input_r,
  input  wire logic [gpio_pkg::SMALL_WIDTH-1:0]      small_pin_in,
  output logic      [gpio_pkg::SMALL_WIDTH-1:0]      small_pin_out_r,
  output logic      [gpio_pkg::SMALL_WIDTH-1:0]      small_pin_oe_r,
  output logic      [gpio_pkg::SMALL_WIDTH-1:0]      small_pullup_r,
  output logic      [71:0]                           other_port_dir
);

  // ----------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------
  cpu_wr_if wr_bus ();

  logic [7:0] reg_q [gpio_pkg::NUM_REGS];

  // Strobe group handed to every register cell
  assign wr_bus.addr    = bus_addr;
  assign wr_bus.wdata   = bus_wdata;
  assign wr_bus.wr      = bus_wr;
  assign wr_bus.bit_wr  = bus_bit_wr;
  assign wr_bus.bit_sel = bus_bit_sel;

  // One cell per direction, latch and pull-up register
  for (genvar i = 0; i < gpio_pkg::NUM_REGS; i++) begin : g_reg
    port_reg8 #(
      .ADDR  (gpio_pkg::REG_ADDR[i]),
      .RESET (gpio_pkg::REG_RESET[i]),
      .WMASK (gpio_pkg::REG_WMASK[i])
    ) u_reg (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .bus     (wr_bus.slave),
      .q       (reg_q[i])
    );
  end

  // Direction registers of the lower ports go out to their pin logic
  // Bank entries 0-8 fill all nine bytes, so no output bit floats
  for (genvar i = 0; i < 9; i++) begin : g_other
    assign other_port_dir[i*8 +: 8] = reg_q[i];
  end

  // ----------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------
  logic [gpio_pkg::ANALOG_WIDTH-1:0]   analog_sync;
  logic [gpio_pkg::CLOCKPIN_WIDTH-1:0] clockpin_sync;
  logic [gpio_pkg::SMALL_WIDTH-1:0]    small_sync;
  logic [gpio_pkg::SMALL_WIDTH+gpio_pkg::CLOCKPIN_WIDTH+gpio_pkg::ANALOG_WIDTH-1:0] all_sync;

  // All pin inputs through one synchroniser
  pin_sync #(
    .WIDTH (gpio_pkg::SMALL_WIDTH + gpio_pkg::CLOCKPIN_WIDTH + gpio_pkg::ANALOG_WIDTH)
  ) u_sync (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .d       ({small_pin_in, clockpin_in, analog_pin_in}),
    .q       (all_sync)
  );

  assign analog_sync   = all_sync[gpio_pkg::ANALOG_WIDTH-1:0];
  assign clockpin_sync = all_sync[gpio_pkg::ANALOG_WIDTH +: gpio_pkg::CLOCKPIN_WIDTH];
  assign small_sync    = all_sync[gpio_pkg::ANALOG_WIDTH+gpio_pkg::CLOCKPIN_WIDTH +:
                                  gpio_pkg::SMALL_WIDTH];

  // ----------------------------------------------------------------
  // Analog-shared port
  // ----------------------------------------------------------------
  logic [3:0] an_dir;
  logic [3:0] an_lat;
  logic [3:0] an_digital;
  logic [3:0] an_drive;
  logic [3:0] an_chan_hit;
  logic [3:0] an_read;
  logic [3:0] chan_index;

  assign an_dir     = reg_q[gpio_pkg::IDX_P9_DIR][3:0];
  assign an_lat     = reg_q[gpio_pkg::IDX_P9_LAT][3:0];
  assign an_digital = analog_pin_config;
  assign chan_index = converter_channel_select - gpio_pkg::FIRST_ANALOG_CHANNEL;

  // Channel decode, pin drive and read-back per bit
  always_comb begin
    for (int b = 0; b < gpio_pkg::ANALOG_WIDTH; b++) begin
      an_chan_hit[b] = (converter_channel_select >= gpio_pkg::FIRST_ANALOG_CHANNEL) &&
                       (chan_index == 4'(b));
      an_drive[b]    = an_digital[b] && !an_dir[b];
      an_read[b]     = !an_digital[b] ? 1'b0 :
                       (an_dir[b] ? analog_sync[b] : an_lat[b]);
    end
  end

  // Analog port pin and converter outputs
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      analog_pin_out_r <= '0;
      analog_pin_oe_r  <= '0;
      analog_convert_r <= '0;
    end else begin
      analog_pin_out_r <= an_lat;
      analog_pin_oe_r  <= an_drive;
      analog_convert_r <= ~an_digital & an_dir & an_chan_hit;
    end
  end

  // ----------------------------------------------------------------
  // Clock-pin port
  // ----------------------------------------------------------------
  logic [4:0] ck_dir;
  logic [4:0] ck_lat;
  logic [4:0] ck_osc;
  logic [4:0] ck_read;

  assign ck_dir = reg_q[gpio_pkg::IDX_P12_DIR][4:0];
  assign ck_lat = reg_q[gpio_pkg::IDX_P12_LAT][4:0];

  // Oscillator selector claims bits 1-4 over direction and latch
  always_comb begin
    ck_osc = '0;
    if (oscillator_mode_select[gpio_pkg::OSC_MAIN_BIT]) begin
      ck_osc = ck_osc | gpio_pkg::OSC_MAIN_PINS;
    end
    if (oscillator_mode_select[gpio_pkg::OSC_SUB_BIT]) begin
      ck_osc = ck_osc | gpio_pkg::OSC_SUB_PINS;
    end
    for (int b = 0; b < gpio_pkg::CLOCKPIN_WIDTH; b++) begin
      ck_read[b] = ck_osc[b] ? 1'b0 : (ck_dir[b] ? clockpin_sync[b] : ck_lat[b]);
    end
  end

  // Clock-pin port pin outputs
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      clockpin_out_r    <= '0;
      clockpin_oe_r     <= '0;
      clockpin_osc_r    <= '0;
      clockpin_pullup_r <= 1'b0;
    end else begin
      clockpin_out_r    <= ck_lat & ~ck_osc;
      clockpin_oe_r     <= ~ck_dir & ~ck_osc;
      clockpin_osc_r    <= ck_osc;
      clockpin_pullup_r <= reg_q[gpio_pkg::IDX_CLOCKPIN_PORT_PULLUP][0] && ck_dir[0];
    end
  end

  // Bit 0 level forwarded to the interrupt and voltage detector inputs
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      external_irq_zero_r     <= 1'b0;
      ext_low_voltage_input_r <= 1'b0;
    end else begin
      external_irq_zero_r     <= clockpin_sync[0];
      ext_low_voltage_input_r <= clockpin_sync[0];
    end
  end

  // ----------------------------------------------------------------
  // Small port
  // ----------------------------------------------------------------
  logic [2:0] sm_dir;
  logic [2:0] sm_lat;
  logic [2:0] sm_read;

  assign sm_dir = reg_q[gpio_pkg::IDX_P13_DIR][2:0];
  assign sm_lat = reg_q[gpio_pkg::IDX_P13_LAT][2:0];

  // Bit 0 always reads its latch, the others follow direction
  always_comb begin
    sm_read[0] = sm_lat[0];
    for (int b = 1; b < gpio_pkg::SMALL_WIDTH; b++) begin
      sm_read[b] = sm_dir[b] ? small_sync[b] : sm_lat[b];
    end
  end

  // Small port pin outputs; bit 0 low through reset
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      small_pin_out_r <= '0;
      small_pin_oe_r  <= 3'h1;
      small_pullup_r  <= '0;
    end else begin
      small_pin_out_r <= sm_lat;
      small_pin_oe_r  <= {~sm_dir[2:1], 1'b1};
      small_pullup_r  <= {reg_q[gpio_pkg::IDX_SMALL_PORT_PULLUP][2:1] & sm_dir[2:1], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  logic [7:0] rd_nxt;

  // Port data reads mix pin and latch; others return stored values
  always_comb begin
    rd_nxt = gpio_pkg::UNMAPPED_READ;
    if (bus_addr == gpio_pkg::REG_ADDR[gpio_pkg::IDX_P9_LAT]) begin
      rd_nxt = {4'h0, an_read};
    end else if (bus_addr == gpio_pkg::REG_ADDR[gpio_pkg::IDX_P12_LAT]) begin
      rd_nxt = {3'h0, ck_read};
    end else if (bus_addr == gpio_pkg::REG_ADDR[gpio_pkg::IDX_P13_LAT]) begin
      rd_nxt = {5'h00, sm_read};
    end else begin
      for (int i = 0; i < gpio_pkg::NUM_REGS; i++) begin
        if (bus_addr == gpio_pkg::REG_ADDR[i]) begin
          rd_nxt = reg_q[i];
        end
      end
    end
  end

  // Read data registered one cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      bus_rdata_r <= '0;
    end else if (bus_rd) begin
      bus_rdata_r <= rd_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  analog_drive_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    analog_pin_oe_r != 4'h0 |-> ($past(an_digital) & ~$past(an_dir)) == analog_pin_oe_r)
    else $error("analog pin driven without digital output mode");

  analog_convert_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (analog_convert_r & analog_pin_oe_r) == 4'h0)
    else $error("converted pin also driven");

  osc_override_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (clockpin_osc_r & clockpin_oe_r) == 5'h00)
    else $error("oscillator pin driven as port");

  pullup_input_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    clockpin_pullup_r |-> !clockpin_oe_r[0])
    else $error("pull-up on while bit 0 is output");

  only_out_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    small_pin_oe_r[0] && !small_pullup_r[0])
    else $error("output-only pin not driving");

  reset_low_a: assert property (@(posedge ref_clk)
    !nrst |=> small_pin_out_r[0] == 1'b0 && small_pin_oe_r[0])
    else $error("output-only pin not low after reset");

  dir_reset_a: assert property (@(posedge ref_clk)
    !nrst |=> reg_q[gpio_pkg::IDX_P13_DIR] == 8'hfe && reg_q[gpio_pkg::IDX_P12_DIR] == 8'hff)
    else $error("direction register reset value wrong");

  small_fixed_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    reg_q[gpio_pkg::IDX_P13_DIR][0] == 1'b0 && reg_q[gpio_pkg::IDX_P12_DIR][7:5] == 3'h7)
    else $error("fixed direction bit changed");

  byte_write_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    bus_wr && !bus_bit_wr && bus_addr == gpio_pkg::REG_ADDR[gpio_pkg::IDX_P9_DIR]
    |=> reg_q[gpio_pkg::IDX_P9_DIR] == {4'hf, $past(bus_wdata[3:0])})
    else $error("byte write to direction register lost");

  read_latch_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    bus_rd && bus_addr == gpio_pkg::REG_ADDR[gpio_pkg::IDX_P13_LAT] && !sm_dir[1]
    |=> bus_rdata_r[1] == $past(sm_lat[1]))
    else $error("output-mode bit does not read its latch");

  small_pullup_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (small_pullup_r & small_pin_oe_r) == 3'h0)
    else $error("small port pull-up on a driven bit");

  analog_reset_a: assert property (@(posedge ref_clk)
    !nrst |=> analog_pin_oe_r == 4'h0 && reg_q[gpio_pkg::IDX_P9_DIR][3:0] == 4'hf)
    else $error("analog port not left as input after reset");

  clockpin_reset_a: assert property (@(posedge ref_clk)
    !nrst |=> clockpin_oe_r == 5'h00 && reg_q[gpio_pkg::IDX_P12_DIR] == 8'hff)
    else $error("clock-pin port not input after reset");

  latch_reset_a: assert property (@(posedge ref_clk)
    !nrst |=> (reg_q[gpio_pkg::IDX_P9_LAT] | reg_q[gpio_pkg::IDX_P12_LAT] |
               reg_q[gpio_pkg::IDX_P13_LAT]) == 8'h00)
    else $error("output latch not cleared by reset");

  osc_latch_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (clockpin_osc_r & clockpin_out_r) == 5'h00)
    else $error("oscillator pin shows port latch");

  bit_write_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    bus_bit_wr && bus_addr == gpio_pkg::REG_ADDR[gpio_pkg::IDX_P12_DIR] && bus_bit_sel == 3'h0
    |=> reg_q[gpio_pkg::IDX_P12_DIR][0] == $past(bus_wdata[0]))
    else $error("bit write to direction register lost");

  dir_buffer_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    clockpin_oe_r[0] == !$past(ck_dir[0]))
    else $error("bit 0 buffer disagrees with its direction bit");

  convert_input_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (analog_convert_r & ~$past(an_dir)) == 4'h0)
    else $error("output-direction pin selected for conversion");

endmodule : gpio_ports

// *** design/gpio_pkg.sv ***
// Package: register map, reset values, field positions for the port block
package gpio_pkg;

  // ----------------------------------------------------------------
  // Register bank indices
  // ----------------------------------------------------------------
  localparam int NUM_REGS   = 16;
  localparam int NUM_DIRS   = 11;
  localparam int IDX_P9_DIR = 8;
  localparam int IDX_P12_DIR = 9;
  localparam int IDX_P13_DIR = 10;
  localparam int IDX_P9_LAT = 11;
  localparam int IDX_P12_LAT = 12;
  localparam int IDX_P13_LAT = 13;
  localparam int IDX_CLOCKPIN_PORT_PULLUP   = 14;
  localparam int IDX_SMALL_PORT_PULLUP   = 15;

  // ----------------------------------------------------------------
  // Addresses, reset values and writable-bit masks
  // ----------------------------------------------------------------
  localparam logic [15:0] REG_ADDR [NUM_REGS] = '{
    16'hff20, 16'hff21, 16'hff23, 16'hff24, 16'hff25, 16'hff26, 16'hff27, 16'hff28,
    16'hff29, 16'hff2c, 16'hff2d, 16'hff09, 16'hff0c, 16'hff0d, 16'hff3c, 16'hff3d};
  localparam logic [7:0] REG_RESET [NUM_REGS] = '{
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hfe, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] REG_WMASK [NUM_REGS] = '{
    8'h63, 8'hff, 8'h0f, 8'h0f, 8'h0f, 8'h0f, 8'h7f, 8'hff,
    8'h0f, 8'h1f, 8'h06, 8'h0f, 8'h1f, 8'h07, 8'h01, 8'h06};

  // ----------------------------------------------------------------
  // Pin fields and oscillator selector bits
  // ----------------------------------------------------------------
  localparam int ANALOG_WIDTH   = 4;
  localparam int CLOCKPIN_WIDTH = 5;
  localparam int SMALL_WIDTH    = 3;
  localparam int OSC_MAIN_BIT   = 6;
  localparam int OSC_SUB_BIT    = 5;
  localparam logic [4:0] OSC_MAIN_PINS = 5'h06;
  localparam logic [4:0] OSC_SUB_PINS  = 5'h18;
  localparam logic [3:0] FIRST_ANALOG_CHANNEL = 4'h8;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

endpackage : gpio_pkg

// *** design/cpu_wr_if.sv ***
// Interface: CPU write strobe group shared by the register cells
`timescale 1ns/1ps
interface cpu_wr_if;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        bit_wr;
  logic [2:0]  bit_sel;

  modport master (output addr, output wdata, output wr, output bit_wr, output bit_sel);
  modport slave  (input addr, input wdata, input wr, input bit_wr, input bit_sel);
endinterface : cpu_wr_if

// *** design/port_reg8.sv ***
// One 8-bit port register cell with byte and single-bit write
`timescale 1ns/1ps
module port_reg8 #(
  parameter logic [15:0] ADDR  = 16'h0000,
  parameter logic [7:0]  RESET = 8'h00,
  parameter logic [7:0]  WMASK = 8'hff
) (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  cpu_wr_if.slave         bus,
  output logic [7:0]      q
);

  logic [7:0] merged;

  // Byte write takes the whole word, bit write only the selected bit
  always_comb begin
    merged = bus.bit_wr ? q : bus.wdata;
    if (bus.bit_wr) begin
      merged[bus.bit_sel] = bus.wdata[bus.bit_sel];
    end
  end

  // Fixed bits keep their reset value whatever is written
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      q <= RESET;
    end else if ((bus.wr || bus.bit_wr) && bus.addr == ADDR) begin
      q <= (merged & WMASK) | (RESET & ~WMASK);
    end
  end

endmodule : port_reg8

// *** design/pin_sync.sv ***
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : pin_sync

// *** test/pin_partner.sv ***
// Pin-side model: one group of pads with outside drivers and pull-ups
`timescale 1ns/1ps
module pin_partner #(
  parameter int W = 4
) (
  input  wire logic         ref_clk,
  input  wire logic [W-1:0] oe,
  input  wire logic [W-1:0] dout,
  input  wire logic [W-1:0] pu,
  input  wire logic [W-1:0] ext_en,
  input  wire logic [W-1:0] ext_val,
  output logic      [W-1:0] lvl
);
  logic [W-1:0] float_r = '0;

  // ----------------------------------------------------------------
  // Pad level
  // ----------------------------------------------------------------
  // A floating line changes every cycle
  always_ff @(posedge ref_clk) begin
    float_r <= ~float_r;
  end

  // Pad drive first, then outside driver, then pull-up
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (oe[i]) begin
        lvl[i] = dout[i];
      end else if (ext_en[i]) begin
        lvl[i] = ext_val[i];
      end else if (pu[i]) begin
        lvl[i] = 1'b1;
      end else begin
        lvl[i] = float_r[i];
      end
    end
  end
endmodule : pin_partner

// *** test/tb_gpio_ports.sv ***
// Testbench: register bank, pin drive, reset and alternate pin use
`timescale 1ns/1ps
module tb_gpio_ports;
  logic        ref_clk;
  logic        nrst;
  logic [15:0] bus_addr;
  logic [7:0]  bus_wdata;
  logic        bus_wr;
  logic        bus_bit_wr;
  logic [2:0]  bus_bit_sel;
  logic        bus_rd;
  logic [7:0]  bus_rdata_r;
  logic [3:0]  analog_pin_config;
  logic [3:0]  converter_channel_select;
  logic [7:0]  oscillator_mode_select;
  logic [3:0]  analog_pin_in;
  logic [3:0]  analog_pin_out_r;
  logic [3:0]  analog_pin_oe_r;
  logic [3:0]  analog_convert_r;
  logic [4:0]  clockpin_in;
  logic [4:0]  clockpin_out_r;
  logic [4:0]  clockpin_oe_r;
  logic [4:0]  clockpin_osc_r;
  logic        clockpin_pullup_r;
  logic        external_irq_zero_r;
  logic        ext_low_voltage_input_r;
  logic [2:0]  small_pin_in;
  logic [2:0]  small_pin_out_r;
  logic [2:0]  small_pin_oe_r;
  logic [2:0]  small_pullup_r;
  logic [71:0] other_port_dir;
  logic [4:0]  c_val;
  logic [3:0]  a_en;
  logic [3:0]  a_val;
  logic [2:0]  s_en;
  logic [2:0]  s_val;
  int          num_errors = 0;
  int          n_compared = 0;

  gpio_ports dut (.ref_clk, .nrst, .bus_addr, .bus_wdata, .bus_wr, .bus_bit_wr, .bus_bit_sel,
    .bus_rd, .bus_rdata_r, .analog_pin_config, .converter_channel_select,
    .oscillator_mode_select, .analog_pin_in, .analog_pin_out_r, .analog_pin_oe_r,
    .analog_convert_r, .clockpin_in, .clockpin_out_r, .clockpin_oe_r, .clockpin_osc_r,
    .clockpin_pullup_r, .external_irq_zero_r, .ext_low_voltage_input_r, .small_pin_in,
    .small_pin_out_r, .small_pin_oe_r, .small_pullup_r, .other_port_dir);

  // ----------------------------------------------------------------
  // Pads
  // ----------------------------------------------------------------
  pin_partner #(.W(4)) pa (.ref_clk(ref_clk), .oe(analog_pin_oe_r), .dout(analog_pin_out_r),
    .pu(4'h0), .ext_en(a_en), .ext_val(a_val), .lvl(analog_pin_in));
  pin_partner #(.W(5)) pc (.ref_clk(ref_clk), .oe(clockpin_oe_r), .dout(clockpin_out_r),
    .pu({4'h0, clockpin_pullup_r}), .ext_en(5'h01), .ext_val(c_val), .lvl(clockpin_in));
  pin_partner #(.W(3)) ps (.ref_clk(ref_clk), .oe(small_pin_oe_r), .dout(small_pin_out_r),
    .pu(small_pullup_r), .ext_en(s_en), .ext_val(s_val), .lvl(small_pin_in));

  // Free-running clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Pass n edges, then settle at the falling edge
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : wt

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge ref_clk);
    bus_wr    <= 1'b0;
  endtask : wr

  task automatic bwr(input logic [15:0] a, input logic [2:0] b, input logic v);
    @(posedge ref_clk);
    bus_addr    <= a;
    bus_bit_sel <= b;
    bus_wdata   <= {8{v}};
    bus_bit_wr  <= 1'b1;
    @(posedge ref_clk);
    bus_bit_wr  <= 1'b0;
  endtask : bwr

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge ref_clk);
    bus_rd   <= 1'b0;
    @(negedge ref_clk);
    chk(bus_rdata_r, exp);
  endtask : rd_chk

  // Six-cycle reset, output-only pin watched inside it
  task automatic do_reset();
    @(posedge ref_clk);
    nrst <= 1'b0;
    wt(1);
    chk(small_pin_out_r[0], 1'b0);
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
  endtask : do_reset

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_vals();
    for (int i = 0; i < 11; i++) begin
      rd_chk(gpio_pkg::REG_ADDR[i], gpio_pkg::REG_RESET[i]);
    end
    chk(other_port_dir, {9{8'hff}});
    chk(analog_pin_oe_r, 4'h0);
    chk(analog_convert_r, 4'h0);
    rd_chk(16'hff09, 8'h00);
    chk(clockpin_oe_r, 5'h00);
    chk(small_pin_oe_r, 3'h1);
    chk({clockpin_out_r, small_pin_out_r}, 8'h00);
    rd_chk(16'hff00, gpio_pkg::UNMAPPED_READ);
  endtask : t_reset_vals

  task automatic t_fixed_bits();
    for (int i = 0; i < 11; i++) begin
      wr(gpio_pkg::REG_ADDR[i], 8'h00);
      rd_chk(gpio_pkg::REG_ADDR[i], gpio_pkg::REG_RESET[i] & ~gpio_pkg::REG_WMASK[i]);
    end
    for (int i = 0; i < 8; i++) begin
      chk(other_port_dir[i*8+:8], gpio_pkg::REG_RESET[i] & ~gpio_pkg::REG_WMASK[i]);
    end
    for (int i = 0; i < 11; i++) begin
      wr(gpio_pkg::REG_ADDR[i], 8'hff);
    end
    bwr(16'hff29, 3'h2, 1'b0);
    rd_chk(16'hff29, 8'hfb);
    bwr(16'hff29, 3'h2, 1'b1);
    bwr(16'hff2d, 3'h0, 1'b1);
    rd_chk(16'hff2d, 8'hfe);
  endtask : t_fixed_bits

  task automatic t_analog();
    @(posedge ref_clk);
    analog_pin_config <= 4'hf;
    wr(16'hff29, 8'h0c);
    wr(16'hff09, 8'h0a);
    wt(4);
    chk(analog_pin_oe_r, 4'h3);
    chk(analog_pin_out_r[1:0], 2'h2);
    rd_chk(16'hff09, 8'h06);
    @(posedge ref_clk);
    a_val <= 4'ha;
    wt(3);
    rd_chk(16'hff09, 8'h0a);
    wr(16'hff29, 8'hff);
    analog_pin_config <= 4'h0;
    wt(2);
    chk(analog_pin_oe_r, 4'h0);
    @(posedge ref_clk);
    converter_channel_select <= 4'h9;
    wt(2);
    chk(analog_convert_r, 4'h2);
    @(posedge ref_clk);
    converter_channel_select <= 4'h3;
    wt(2);
    chk(analog_convert_r, 4'h0);
  endtask : t_analog

  task automatic t_clockpin();
    wr(16'hff2c, 8'h00);
    wr(16'hff0c, 8'h15);
    wt(2);
    chk(clockpin_oe_r, 5'h1f);
    chk(clockpin_out_r, 5'h15);
    @(posedge ref_clk);
    oscillator_mode_select <= 8'h40;
    wt(2);
    chk(clockpin_osc_r, 5'h06);
    chk(clockpin_oe_r, 5'h19);
    chk(clockpin_out_r, 5'h11);
    @(posedge ref_clk);
    oscillator_mode_select <= 8'h60;
    wt(2);
    chk(clockpin_osc_r, 5'h1e);
    chk(clockpin_oe_r, 5'h01);
    @(posedge ref_clk);
    oscillator_mode_select <= 8'h00;
    c_val <= 5'h01;
    wr(16'hff2c, 8'hff);
    wr(16'hff3c, 8'h01);
    wt(4);
    chk(clockpin_pullup_r, 1'b1);
    chk({external_irq_zero_r, ext_low_voltage_input_r}, 2'h3);
    @(posedge ref_clk);
    c_val <= 5'h00;
    wt(4);
    chk({external_irq_zero_r, ext_low_voltage_input_r}, 2'h0);
    bwr(16'hff2c, 3'h0, 1'b0);
    wt(2);
    chk(clockpin_pullup_r, 1'b0);
    chk(clockpin_oe_r, 5'h01);
  endtask : t_clockpin

  task automatic t_small();
    wr(16'hff2d, 8'h00);
    rd_chk(16'hff2d, 8'hf8);
    wr(16'hff0d, 8'h07);
    wt(2);
    chk(small_pin_oe_r, 3'h7);
    chk(small_pin_out_r, 3'h7);
    rd_chk(16'hff0d, 8'h07);
    wr(16'hff2d, 8'hff);
    wr(16'hff3d, 8'h06);
    wt(4);
    chk({small_pin_oe_r, small_pin_out_r[0]}, 4'h3);
    chk(small_pullup_r, 3'h6);
    rd_chk(16'hff0d, 8'h07);
    @(posedge ref_clk);
    s_en <= 3'h4;
    wt(3);
    rd_chk(16'hff0d, 8'h03);
  endtask : t_small

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    final_report();
  end

  // Main sequence
  initial begin
    nrst = 1'b0;
    bus_addr = 16'h0000;
    bus_wdata = 8'h00;
    {bus_wr, bus_bit_wr, bus_rd} = 3'h0;
    bus_bit_sel = 3'h0;
    analog_pin_config = 4'h0;
    converter_channel_select = 4'h0;
    oscillator_mode_select = 8'h00;
    c_val = 5'h00;
    {a_en, a_val, s_en, s_val} = {4'hf, 4'h5, 3'h0, 3'h0};
    do_reset();
    t_reset_vals();
    t_fixed_bits();
    t_analog();
    t_clockpin();
    t_small();
    @(posedge ref_clk);
    analog_pin_config <= 4'h0;
    converter_channel_select <= 4'h0;
    do_reset();
    t_reset_vals();
    final_report();
  end
endmodule : tb_gpio_ports
